/* File: inc/fieldbus_slave_consts.svh */
/*
  constants of the fieldbus display / switch slave: switch fields,
  configuration codes, diagnosis layout, digit codes, flash timing.
  assumes inclusion by bare name from the package and the bench.
*/
`ifndef FIELDBUS_SLAVE_CONSTS_SVH
`define FIELDBUS_SLAVE_CONSTS_SVH

// configuration switch fields
`define SW_SIGN_BIT       0
`define SW_ADDR_LSB       1
`define SW_ADDR_MSB       6
`define ADDR_MIN          7'h03
`define ADDR_MAX          7'h7E

// configuration bytes per variant
`define CFG_DISPLAY_ONLY  8'hA3
`define CFG_SWITCH_ONLY   8'h93
`define CFG_BOTH          8'hB3

// diagnosis layout
`define DIAG_STD_BYTES    4'h6
`define DIAG_TOTAL_BYTES  4'hB
`define DIAG_LEN_BYTE     8'h05
`define DIAG_STATUS_TYPE  8'h81
`define DIAG_SLOT_INDEX   8'h00
`define DIAG_SPECIFIER    8'h00
`define DIAG_CFG_FAULT    2
`define DIAG_MASTER_NONE  8'hFF
`define ERR_BAD_ADDRESS   8'h01

// display range and digit codes
`define DISP_MAX          32'sd999999
`define DISP_MIN          (-32'sd99999)
`define DIG_BLANK         4'hA
`define DIG_DASH          4'hB
`define DIG_E             4'hC
`define DIG_UNDER         4'hD
`define DP_MAX            8'h05

// led flash half periods and clock rate
`define MCLK_HZ           20000000
`define SLOW_HALF_MS      500
`define FAST_HALF_MS      100
`define BIN_BITS          20

`endif

/* File: inc/fieldbus_slave_pkg.sv */
/*
  types of the fieldbus display / switch slave.
  assumes the constants header sits beside it in inc/.
*/
package fieldbus_slave_pkg;
  `include "fieldbus_slave_consts.svh"

  typedef enum logic [4:0] {
    st_power_on = 5'b0_0001,
    st_wait_prm = 5'b0_0010,
    st_wait_cfg = 5'b0_0100,
    st_data_xch = 5'b0_1000,
    st_fatal    = 5'b1_0000
  } slave_state_type;
endpackage

/* File: hdl/fieldbus_display_switch_slave.sv */
/*
  application logic of a fieldbus slave: state tracking, bit rate
  detection, display of received values through an 8 word fifo, switch
  value return, diagnosis bytes, led state indication on variants without display.
  assumes a telegram engine on mclk that presents decoded services as
  one-cycle pulses and bytes; pins (rxd, switches, key) are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module data_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem[rd_q];

  always_comb begin
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
    if (srst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// Contract
// - bit rate found from line activity at start-up; 9.6k to 12M.
// - station address from six switch positions, valid 3 to 126.
// - set-slave-address requests are always refused.
// - one switch position selects numeral or sign for top digit.
// - sign variant needs that position on; range -99999 to +99999.
// - address and sign switches sampled once after reset only.
// - parameter message ends in one user byte: decimal point position.
// - diagnosis: six standard bytes then 05, 81, 00, 00, error.
// - data exchange only after parameters and configuration accepted.
// - input and output values are signed 32-bit.
// - received values shown on display at once.
// - values outside -99999..999999 show dashes.
// - enter key latches switch value for the next exchange.
// - six bcd decades, range 0 to 999999.
// - display shows blanks, waiting dashes, data, or error with code.
// - led off, slow flash, on, fast flash per state; always off on display variants.
// - fatal error holds until power cycle.
module fieldbus_display_switch_slave
  import fieldbus_slave_pkg::*;
#(
  parameter bit      HAS_DISPLAY  = 1'b1,
  parameter bit      HAS_SWITCHES = 1'b1,
  parameter logic [7:0] IDENT_HI  = 8'h12, // arbitrary value
  parameter logic [7:0] IDENT_LO  = 8'h34, // arbitrary value
  parameter int      SLOW_CYC = `MCLK_HZ / 1000 * `SLOW_HALF_MS,
  parameter int      FAST_CYC = `MCLK_HZ / 1000 * `FAST_HALF_MS
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  // pins
  input  wire logic        rxd_pin,
  input  wire logic [6:0]  dil_pin,
  input  wire logic [23:0] thumb_pin,
  input  wire logic        enter_pin,
  // services from the telegram engine
  input  wire logic        prm_valid,
  input  wire logic [7:0]  prm_user,
  input  wire logic        cfg_valid,
  input  wire logic [7:0]  cfg_byte,
  input  wire logic        set_addr_req,
  input  wire logic        fatal_req,
  input  wire logic [7:0]  fatal_code,
  input  wire logic        dout_valid,
  output logic             dout_ready,
  input  wire logic [31:0] dout_data,
  input  wire logic [3:0]  diag_index,
  // to the telegram engine
  output logic [15:0]      bit_time,
  output logic [6:0]       station_addr,
  output logic             set_addr_nak,
  output logic             xch_enable,
  output logic [31:0]      din_data,
  output logic [7:0]       diag_byte,
  // front panel
  output logic [23:0]      disp_digits,
  output logic [2:0]       disp_point,
  output logic             led_on
);
  localparam logic [7:0] CFG_OK = (HAS_DISPLAY && HAS_SWITCHES) ?
    `CFG_BOTH : (HAS_DISPLAY ? `CFG_DISPLAY_ONLY : `CFG_SWITCH_ONLY);

  // two-stage synchronisers for every pin
  logic [32:0] pin_m_q, pin_s_q;
  always_ff @(posedge mclk) begin
    pin_m_q <= {rxd_pin, enter_pin, dil_pin, thumb_pin};
    pin_s_q <= pin_m_q;
  end
  logic        rxd_s, enter_s;
  logic [6:0]  dil_s;
  logic [23:0] thumb_s;
  assign {rxd_s, enter_s, dil_s, thumb_s} = pin_s_q;

  // main state, switches, bit rate, diagnosis
  slave_state_type st_q, st_d;
  logic [6:0]  addr_q, addr_d;
  logic        sign_q, sign_d, cfg_flt_q, cfg_flt_d, nak_q, nak_d;
  logic [7:0]  err_q, err_d, diag_q, diag_d;
  logic [2:0]  dp_q, dp_d;
  logic [15:0] run_q, run_d, bt_q, bt_d;
  logic        rxd_d1_q;
  logic        enter_d1_q;
  logic [31:0] din_q, din_d, sw_val;
  logic [19:0] sw_mag;

  // bcd to binary; with the sign option the top decade is only a sign
  always_comb begin
    sw_mag = '0;
    for (int i = 5; i >= 0; i--) begin
      if (i < 5 || !sign_q) begin
        sw_mag = 20'(sw_mag * 20'd10) + 20'(thumb_s[4*i +: 4]);
      end
    end
    sw_val = (sign_q && thumb_s[23:20] != 4'h0) ?
      -$signed({12'h000, sw_mag}) : $signed({12'h000, sw_mag});
  end

  always_comb begin
    st_d      = st_q;
    addr_d    = addr_q;
    sign_d    = sign_q;
    cfg_flt_d = cfg_flt_q;
    err_d     = err_q;
    dp_d      = dp_q;
    nak_d     = set_addr_req;
    din_d     = din_q;
    bt_d      = bt_q;
    run_d     = (rxd_s == rxd_d1_q && run_q != 16'hFFFF) ? run_q + 16'h0001
                                                         : 16'h0001;
    // shortest level run while starting up gives one bit time
    if (rxd_s != rxd_d1_q && run_q < bt_q &&
        (st_q == st_wait_prm || st_q == st_wait_cfg)) begin
      bt_d = run_q;
    end
    if (HAS_SWITCHES && enter_s && !enter_d1_q) begin
      din_d = sw_val;
    end
    case (st_q)
      st_power_on: begin
        addr_d = dil_s[`SW_ADDR_MSB:`SW_ADDR_LSB];
        sign_d = dil_s[`SW_SIGN_BIT];
        if (dil_s[`SW_ADDR_MSB:`SW_ADDR_LSB] < `ADDR_MIN ||
            dil_s[`SW_ADDR_MSB:`SW_ADDR_LSB] > `ADDR_MAX) begin
          err_d = `ERR_BAD_ADDRESS;
          st_d  = st_fatal;
        end else begin
          st_d = st_wait_prm;
        end
      end
      st_wait_prm: begin
        if (prm_valid && prm_user <= `DP_MAX) begin
          dp_d = prm_user[2:0];
          st_d = st_wait_cfg;
        end
      end
      st_wait_cfg: begin
        if (cfg_valid) begin
          cfg_flt_d = cfg_byte != CFG_OK;
          st_d      = (cfg_byte == CFG_OK) ? st_data_xch : st_wait_cfg;
        end else if (prm_valid && prm_user <= `DP_MAX) begin
          dp_d = prm_user[2:0];
        end
      end
      st_data_xch: begin
        if (prm_valid) begin
          st_d = st_wait_prm;
        end
      end
      st_fatal: st_d = st_fatal;
      default:  st_d = st_fatal;
    endcase
    if (fatal_req && st_q != st_fatal) begin
      st_d  = st_fatal;
      err_d = fatal_code;
    end
    case (diag_index)
      4'h0:    diag_d = {5'b0_0000, cfg_flt_q, 2'b00};
      4'h1:    diag_d = {6'b00_0000, st_q != st_data_xch, 1'b0};
      4'h2:    diag_d = 8'h00;
      4'h3:    diag_d = `DIAG_MASTER_NONE;
      4'h4:    diag_d = IDENT_HI;
      4'h5:    diag_d = IDENT_LO;
      4'h6:    diag_d = `DIAG_LEN_BYTE;
      4'h7:    diag_d = `DIAG_STATUS_TYPE;
      4'h8:    diag_d = `DIAG_SLOT_INDEX;
      4'h9:    diag_d = `DIAG_SPECIFIER;
      4'hA:    diag_d = err_q;
      default: diag_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q       <= st_power_on;
      addr_q     <= 7'h00;
      sign_q     <= 1'b0;
      cfg_flt_q  <= 1'b0;
      err_q      <= 8'h00;
      dp_q       <= 3'h0;
      nak_q      <= 1'b0;
      din_q      <= 32'h0000_0000;
      bt_q       <= 16'hFFFF;
      run_q      <= 16'h0001;
      diag_q     <= 8'h00;
      rxd_d1_q   <= 1'b1;
      enter_d1_q <= 1'b1;
    end else begin
      st_q       <= st_d;
      addr_q     <= addr_d;
      sign_q     <= sign_d;
      cfg_flt_q  <= cfg_flt_d;
      err_q      <= err_d;
      dp_q       <= dp_d;
      nak_q      <= nak_d;
      din_q      <= din_d;
      bt_q       <= bt_d;
      run_q      <= run_d;
      diag_q     <= diag_d;
      rxd_d1_q   <= rxd_s;
      enter_d1_q <= enter_s;
    end
  end

  // received values queue up so a burst of up to 8 need not wait on conversion
  logic        fifo_valid, fifo_ready, fifo_in_ready;
  logic [31:0] fifo_data;
  data_fifo #(.WIDTH(32), .DEPTH(8)) u_fifo (
    .mclk      (mclk),
    .srst      (srst),
    .in_valid  (dout_valid && dout_ready && st_q == st_data_xch),
    .in_ready  (fifo_in_ready),
    .in_data   (dout_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  // shift-add-3 conversion, 20 cycles per value
  logic        busy_q, busy_d, neg_q, neg_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [19:0] bin_q, bin_d;
  logic [23:0] bcd_q, bcd_d, shown_q, shown_d, adj;
  logic [31:0] mag;

  assign fifo_ready = !busy_q;
  assign mag        = $signed(fifo_data) < 0 ? -fifo_data : fifo_data;

  always_comb begin
    busy_d  = busy_q;
    neg_d   = neg_q;
    cnt_d   = cnt_q;
    bin_d   = bin_q;
    bcd_d   = bcd_q;
    shown_d = shown_q;
    for (int i = 0; i < 6; i++) begin
      adj[4*i +: 4] = (bcd_q[4*i +: 4] > 4'h4) ? bcd_q[4*i +: 4] + 4'h3
                                               : bcd_q[4*i +: 4];
    end
    if (busy_q) begin
      {bcd_d, bin_d} = {adj[22:0], bin_q, 1'b0};
      cnt_d = cnt_q - 5'd1;
      if (cnt_q == 5'd1) begin
        busy_d  = 1'b0;
        shown_d = neg_q ? {`DIG_DASH, bcd_d[19:0]} : bcd_d;
      end
    end else if (fifo_valid) begin
      if ($signed(fifo_data) > `DISP_MAX ||
          $signed(fifo_data) < `DISP_MIN) begin
        shown_d = {6{`DIG_DASH}};
      end else begin
        busy_d = 1'b1;
        neg_d  = fifo_data[31];
        bin_d  = mag[19:0];
        bcd_d  = '0;
        cnt_d  = 5'(`BIN_BITS);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_q  <= 1'b0;
      neg_q   <= 1'b0;
      cnt_q   <= 5'd0;
      bin_q   <= '0;
      bcd_q   <= '0;
      shown_q <= {6{`DIG_BLANK}};
    end else begin
      busy_q  <= busy_d;
      neg_q   <= neg_d;
      cnt_q   <= cnt_d;
      bin_q   <= bin_d;
      bcd_q   <= bcd_d;
      shown_q <= shown_d;
    end
  end

  // panel: flash enables from one divider each
  logic [23:0] slow_q, slow_d, fast_q, fast_d;
  logic        slow_ph_q, slow_ph_d, fast_ph_q, fast_ph_d, led_d;
  logic [23:0] disp_d;
  always_comb begin
    slow_d    = (slow_q >= 24'(SLOW_CYC - 1)) ? 24'd0 : slow_q + 24'd1;
    fast_d    = (fast_q >= 24'(FAST_CYC - 1)) ? 24'd0 : fast_q + 24'd1;
    slow_ph_d = (slow_d == 24'd0) ? !slow_ph_q : slow_ph_q;
    fast_ph_d = (fast_d == 24'd0) ? !fast_ph_q : fast_ph_q;
    case (st_q)
      st_power_on: begin
        disp_d = {6{`DIG_BLANK}};
        led_d  = 1'b0;
      end
      st_wait_prm, st_wait_cfg: begin
        disp_d = {6{`DIG_DASH}};
        led_d  = slow_ph_q;
      end
      st_data_xch: begin
        disp_d = shown_q;
        led_d  = 1'b1;
      end
      st_fatal: begin
        disp_d = {`DIG_UNDER, `DIG_E, 4'h0, err_q, `DIG_UNDER};
        led_d  = fast_ph_q;
      end
      default: begin
        disp_d = {6{`DIG_BLANK}};
        led_d  = 1'b0;
      end
    endcase
    if (!HAS_DISPLAY) begin
      disp_d = {6{`DIG_BLANK}};
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      slow_q      <= 24'd0;
      fast_q      <= 24'd0;
      slow_ph_q   <= 1'b0;
      fast_ph_q   <= 1'b0;
      disp_digits <= {6{`DIG_BLANK}};
      led_on      <= 1'b0;
      dout_ready  <= 1'b0;
    end else begin
      slow_q      <= slow_d;
      fast_q      <= fast_d;
      slow_ph_q   <= slow_ph_d;
      fast_ph_q   <= fast_ph_d;
      disp_digits <= disp_d;
      led_on      <= led_d && !HAS_DISPLAY;
      // registered ready lags a cycle, so drop it for the cycle after each take
      dout_ready  <= fifo_in_ready && !(dout_valid && dout_ready);
    end
  end

  assign bit_time     = bt_q;
  assign station_addr = addr_q;
  assign set_addr_nak = nak_q;
  assign xch_enable   = st_q[3];
  assign din_data     = din_q;
  assign diag_byte    = diag_q;
  assign disp_point   = dp_q;
endmodule

`default_nettype wire

/* File: tb/slave_assertions.sv */
/*
  port checker of the fieldbus slave.
  assumes binding to the top module, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module slave_assertions #(
  parameter bit HAS_DISPLAY  = 1'b1,
  parameter bit HAS_SWITCHES = 1'b1
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        srst,
  // inputs
  input wire logic        enter_pin,
  input wire logic        cfg_valid,
  input wire logic [7:0]  cfg_byte,
  input wire logic        set_addr_req,
  input wire logic        fatal_req,
  input wire logic [3:0]  diag_index,
  // outputs
  input wire logic [15:0] bit_time,
  input wire logic [6:0]  station_addr,
  input wire logic        set_addr_nak,
  input wire logic        xch_enable,
  input wire logic [31:0] din_data,
  input wire logic [7:0]  diag_byte,
  input wire logic        led_on
);
  localparam logic [7:0] CFG_OK = !HAS_DISPLAY ? 8'h93 :
                                  (HAS_SWITCHES ? 8'hB3 : 8'hA3);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  bit_rst_a: assert property ($fell(srst) |-> bit_time == 16'hFFFF)
    else $error("bit time not cleared by reset");
  addr_hold_a: assert property (!$past(srst) && !$past(srst, 2) |->
    $stable(station_addr))
    else $error("station address moved after start");
  addr_refuse_a: assert property (set_addr_req |=>
    set_addr_nak && $stable(station_addr))
    else $error("address change not refused");
  xch_start_a: assert property ($rose(xch_enable) |->
    $past(cfg_valid) && $past(cfg_byte) == CFG_OK)
    else $error("exchange began without a good configuration");
  fatal_hold_a: assert property (fatal_req |=> !xch_enable [*8])
    else $error("left fatal state");
  diag_len_a: assert property (diag_index == 4'h6 |=>
    diag_byte == 8'h05)
    else $error("diag length byte wrong");
  diag_type_a: assert property (diag_index == 4'h7 |=>
    diag_byte == 8'h81)
    else $error("diag status type wrong");
  led_dark_a: assert property (HAS_DISPLAY |-> !led_on)
    else $error("led lit on a display variant");
  din_key_a: assert property ($changed(din_data) |-> $past(enter_pin, 2)
    || $past(enter_pin, 3) || $past(enter_pin, 4))
    else $error("input value changed without the key");
endmodule

bind fieldbus_display_switch_slave slave_assertions #(
  .HAS_DISPLAY(HAS_DISPLAY), .HAS_SWITCHES(HAS_SWITCHES)
) slave_assertions_inst (
  .mclk, .srst, .enter_pin, .cfg_valid, .cfg_byte, .set_addr_req,
  .fatal_req, .diag_index, .bit_time, .station_addr, .set_addr_nak,
  .xch_enable, .din_data, .diag_byte, .led_on
);

`default_nettype wire

/* File: tb/master_model.sv */
/*
  master side model: service pulses and output values.
  assumes inputs sampled on the rising edge of mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module master_model (
  // clock and flow
  input  wire logic        mclk,
  input  wire logic        dout_ready,
  // services
  output logic             prm_valid,
  output logic [7:0]       prm_user,
  output logic             cfg_valid,
  output logic [7:0]       cfg_byte,
  output logic             set_addr_req,
  output logic             fatal_req,
  output logic [7:0]       fatal_code,
  output logic             dout_valid,
  output logic [31:0]      dout_data
);
  initial begin
    {prm_valid, cfg_valid, set_addr_req, fatal_req, dout_valid} = 0;
    {prm_user, cfg_byte, fatal_code, dout_data} = 0;
  end

  task automatic step;
    @(posedge mclk);
    #1;
  endtask

  // released fields show the inverse, not a stale copy
  task automatic prm(input logic [7:0] u);
    prm_user = u;
    prm_valid = 1;
    step;
    prm_valid = 0;
    prm_user = ~u;
    step;
  endtask

  task automatic cfg(input logic [7:0] b);
    cfg_byte = b;
    cfg_valid = 1;
    step;
    cfg_valid = 0;
    cfg_byte = ~b;
  endtask

  task automatic fatal(input logic [7:0] c);
    fatal_code = c;
    fatal_req = 1;
    step;
    fatal_req = 0;
    fatal_code = ~c;
  endtask

  task automatic set_addr;
    set_addr_req = 1;
    step;
    set_addr_req = 0;
  endtask

  // held until taken; g idle cycles after, 0 keeps valid up
  task automatic push(input logic [31:0] v, input int g);
    logic r;
    dout_data = v;
    dout_valid = 1;
    do begin
      r = dout_ready;
      step;
    end while (!r);
    if (g > 0) begin
      dout_valid = 0;
      dout_data = ~v;
      repeat (g) step;
    end
  endtask
endmodule

`default_nettype wire

/* File: tb/fieldbus_display_switch_slave_bench.sv */
/*
  self-checking bench of the fieldbus slave.
  assumes master model and checker compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fieldbus_slave_consts.svh"

module fieldbus_display_switch_slave_bench;
  logic        mclk, srst, rxd_pin, enter_pin;
  logic [6:0]  dil_pin;
  logic [23:0] thumb_pin, disp_digits, last_disp;
  logic [3:0]  diag_index;
  logic        prm_valid, cfg_valid, set_addr_req, fatal_req, dout_valid;
  logic [7:0]  prm_user, cfg_byte, fatal_code, diag_byte;
  logic [31:0] dout_data, din_data;
  logic [15:0] bit_time;
  logic [6:0]  station_addr;
  logic [2:0]  disp_point;
  logic        dout_ready, set_addr_nak, xch_enable, led_on;
  logic [23:0] shown_q [$];
  logic [11:0] dg [6] = '{12'h412, 12'h534, 12'h605, 12'h781, 12'h800,
                          12'h900};
  int          vals [7] = '{999999, 1000000, -99999, -100000, 0, 5, -7};
  int          bad_count, comparisons, seed = 32'he019;
  bit          watch, saw_full;

  fieldbus_display_switch_slave #(.SLOW_CYC(8), .FAST_CYC(4))
  fieldbus_display_switch_slave_inst (
    .mclk, .srst, .rxd_pin, .dil_pin, .thumb_pin, .enter_pin, .prm_valid,
    .prm_user, .cfg_valid, .cfg_byte, .set_addr_req, .fatal_req,
    .fatal_code, .dout_valid, .dout_ready, .dout_data, .diag_index,
    .bit_time, .station_addr, .set_addr_nak, .xch_enable, .din_data,
    .diag_byte, .disp_digits, .disp_point, .led_on
  );

  master_model master_model_inst (
    .mclk, .dout_ready, .prm_valid, .prm_user, .cfg_valid, .cfg_byte,
    .set_addr_req, .fatal_req, .fatal_code, .dout_valid, .dout_data
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic do_reset(input logic [6:0] d);
    srst = 1;
    dil_pin = d;
    tick(10);
    check(disp_digits, {6{`DIG_BLANK}});
    srst = 0;
    tick(3);
  endtask

  task automatic rd(input logic [3:0] i);
    diag_index = i;
    tick(2);
  endtask

  function automatic logic [23:0] digits(input int v);
    logic [23:0] r;
    int m;
    m = v < 0 ? -v : v;
    for (int i = 0; i < 6; i++) begin
      r[i*4 +: 4] = 4'(m % 10);
      m = m / 10;
    end
    if (v < 0) r[23:20] = `DIG_DASH;
    if (v > `DISP_MAX || v < `DISP_MIN) r = {6{`DIG_DASH}};
    return r;
  endfunction

  // sign option turns a nonzero top digit into a minus
  task automatic latch(input logic [23:0] t, input logic s);
    int v = 0;
    for (int i = s ? 4 : 5; i >= 0; i--) v = v * 10 + t[i*4 +: 4];
    if (s && t[23:20] != 0) v = -v;
    thumb_pin = t;
    tick(4);
    enter_pin = 1;
    tick(6);
    enter_pin = 0;
    tick(4);
    check(din_data, v);
  endtask

  task automatic send(input int v, input int g);
    shown_q.push_back(digits(v));
    master_model_inst.push(v, g);
  endtask

  task automatic start;
    master_model_inst.prm(8'h05);
    master_model_inst.cfg(8'hB3);
    tick(3);
  endtask

  always @(posedge mclk) begin
    if (dout_valid && !dout_ready) saw_full = 1;
    if (watch && disp_digits !== last_disp) begin
      last_disp = disp_digits;
      if (shown_q.size() == 0) check(1, 0);
      else check(disp_digits, shown_q.pop_front());
    end
  end

  initial begin
    #1_000_000;
    bad_count++;
    final_report();
  end

  initial begin
    srst = 1'b1;
    rxd_pin = 1'b1;
    enter_pin = 1'b0;
    dil_pin = 7'h7E;
    thumb_pin = 24'h00_0000;
    diag_index = 4'h0;
    do_reset(7'h7E);
    check(station_addr, 7'd63);
    dil_pin = 7'h07;
    tick(5);
    check(station_addr, 7'd63);
    repeat (6) begin
      rxd_pin = ~rxd_pin;
      tick(12);
    end
    check(bit_time inside {[11:13]}, 1);
    master_model_inst.prm(8'h05);
    master_model_inst.cfg(8'h93);
    tick(3);
    check(xch_enable, 0);
    rd(0);
    check(diag_byte[2], 1);
    master_model_inst.cfg(8'hB3);
    tick(3);
    check(xch_enable, 1);
    check(disp_point, 3'd5);
    foreach (dg[i]) begin
      rd(dg[i][11:8]);
      check(diag_byte, dg[i][7:0]);
    end
    master_model_inst.set_addr();
    tick(2);
    check(station_addr, 7'd63);
    last_disp = disp_digits;
    watch = 1;
    // back to back fills the fifo; the converter is the stall
    foreach (vals[i]) send(vals[i], 0);
    repeat (8) send($unsigned($random(seed)) % 1000000, 0);
    repeat (2) send($unsigned($random(seed)) % 1000000, 6);
    for (int k = 0; k < 3000 && shown_q.size() > 0; k++) tick(1);
    check(shown_q.size(), 0);
    check(saw_full, 1);
    watch = 0;
    latch(24'h12_3456, 0);
    latch(24'h99_9999, 0);
    master_model_inst.fatal(8'h25);
    tick(3);
    check(disp_digits, 24'hDC_025D);
    start();
    check(xch_enable, 0);
    rd(10);
    check(diag_byte, 8'h25);
    do_reset(7'h07);
    check(station_addr, 7'd3);
    start();
    latch(24'h51_2345, 1);
    latch(24'h01_2345, 1);
    do_reset(7'h04);
    start();
    check(xch_enable, 0);
    rd(10);
    check(diag_byte, 8'h01);
    final_report();
  end
endmodule

`default_nettype wire
